// >>> virt_ctl_fields.sv
`include "virt_ctl_regs.svh"

module virt_ctl_fields #(
    parameter bit HAS_TRANSLATION = 1'b1,
    parameter bit HAS_TAG = 1'b1,
    parameter bit HAS_PAUSE_EXIT = 1'b1,
    parameter bit HAS_SECONDARY = 1'b1,
    parameter bit HAS_GUEST_FUNC = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic timestamp_tick,
    input wire logic guest_running,
    input wire logic pause_exec,
    output logic pause_exit,
    input wire logic entry_req,
    output logic entry_ok,
    output logic entry_fail,
    input wire logic func_req,
    input wire logic [8:0] func_index,
    output logic func_fault,
    output logic list_rd_req,
    output logic [63:0] list_rd_addr,
    input wire logic list_rd_valid,
    input wire logic [63:0] list_rd_data,
    output logic [63:0] active_pointer,
    output logic [3:0] walk_length,
    output logic [2:0] walk_mem_type,
    output logic [63:0] top_level_table,
    output logic [15:0] active_tag,
    input wire logic exit_req,
    input wire logic exit_ext_intr,
    input wire logic [7:0] intr_ctrl_vector,
    output logic exit_done,
    output virt_ctl_pkg::exit_actions_s exit_actions
);
    localparam bit HAS_FUNC = HAS_SECONDARY & HAS_GUEST_FUNC;
    localparam bit HAS_LIST = HAS_FUNC;

    virt_ctl_pkg::bus_phase_s aphase;
    virt_ctl_pkg::switch_state_e sw_state;
    virt_ctl_pkg::switch_state_e next_sw_state;

    logic [63:0] second_level_table_pointer;
    logic [15:0] virtual_processor_tag;
    logic [31:0] pause_gap_limit;
    logic [31:0] pause_window_limit;
    logic [63:0] guest_function_controls;
    logic [63:0] pointer_list_address;
    logic [31:0] exit_control_vector;
    logic [31:0] gap_count;
    logic [31:0] window_count;
    logic in_loop;
    logic [63:0] fetched_pointer;

    function automatic logic mem_type_ok(input logic [63:0] ptr);
        mem_type_ok = (ptr[`MT_MSB:`MT_LSB] == `MT_UNCACHEABLE) ||
                      (ptr[`MT_MSB:`MT_LSB] == `MT_WRITE_BACK);
    endfunction

    // Bits 11:6 and those at or above the address width must stay clear
    function automatic logic ptr_reserved_clear(input logic [63:0] ptr);
        logic [63:0] legal;
        legal = {{(64 - `PHYS_WIDTH){1'b0}}, {(`PHYS_WIDTH - `BASE_LSB){1'b1}},
                 6'h00, {(`WALK_MSB + 1){1'b1}}};
        ptr_reserved_clear = (ptr & ~legal) == 64'h0;
    endfunction

    // Bus side: one-cycle address phase, zero-wait data phase
    wire addr_take = hsel & htrans[1] & hready;
    wire wr_en = aphase.valid & aphase.write;
    wire wr_ptr_lo = wr_en & (aphase.addr == `OFS_PTR_LO) & HAS_TRANSLATION;
    wire wr_ptr_hi = wr_en & (aphase.addr == `OFS_PTR_HI) & HAS_TRANSLATION;
    wire wr_tag = wr_en & (aphase.addr == `OFS_TAG) & HAS_TAG;
    wire wr_gap = wr_en & (aphase.addr == `OFS_GAP) & HAS_PAUSE_EXIT;
    wire wr_window = wr_en & (aphase.addr == `OFS_WINDOW) & HAS_PAUSE_EXIT;
    wire wr_func_lo = wr_en & (aphase.addr == `OFS_FUNC_LO) & HAS_FUNC;
    wire wr_func_hi = wr_en & (aphase.addr == `OFS_FUNC_HI) & HAS_FUNC;
    wire wr_list_lo = wr_en & (aphase.addr == `OFS_LIST_LO) & HAS_LIST;
    wire wr_list_hi = wr_en & (aphase.addr == `OFS_LIST_HI) & HAS_LIST;
    wire wr_exit = wr_en & (aphase.addr == `OFS_EXIT);

    wire func_reserved_set = |(guest_function_controls & ~`FUNC_DEFINED_MASK);
    wire ptr_ok = !HAS_TRANSLATION ||
                  (mem_type_ok(second_level_table_pointer) &&
                   ptr_reserved_clear(second_level_table_pointer));
    wire entry_good = !func_reserved_set && ptr_ok;

    wire [31:0] status_word = {24'h0, sw_state, in_loop, func_reserved_set,
                               ptr_ok, entry_good, HAS_FUNC, HAS_TRANSLATION};

    logic [31:0] rd_mux;
    wire [7:0] rd_addr = haddr[7:0];
    always_comb begin
        unique case (rd_addr)
            `OFS_PTR_LO: rd_mux = second_level_table_pointer[31:0];
            `OFS_PTR_HI: rd_mux = second_level_table_pointer[63:32];
            `OFS_TAG: rd_mux = {16'h0, virtual_processor_tag};
            `OFS_GAP: rd_mux = pause_gap_limit;
            `OFS_WINDOW: rd_mux = pause_window_limit;
            `OFS_FUNC_LO: rd_mux = guest_function_controls[31:0];
            `OFS_FUNC_HI: rd_mux = guest_function_controls[63:32];
            `OFS_LIST_LO: rd_mux = pointer_list_address[31:0];
            `OFS_LIST_HI: rd_mux = pointer_list_address[63:32];
            `OFS_EXIT: rd_mux = exit_control_vector;
            `OFS_STATUS: rd_mux = status_word;
            default: rd_mux = `RST_WORD;
        endcase
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aphase <= '0;
            hrdata <= `RST_WORD;
        end else begin
            aphase.valid <= addr_take;
            aphase.write <= hwrite;
            aphase.addr <= haddr[7:0];
            hrdata <= (addr_take && !hwrite) ? rd_mux : `RST_WORD;
        end
    end

    // Absent fields other than the pointer, which a completed list switch loads, keep their reset value and read as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            virtual_processor_tag <= `RST_TAG;
            pause_gap_limit <= `RST_WORD;
            pause_window_limit <= `RST_WORD;
            exit_control_vector <= `RST_WORD;
        end else begin
            if (wr_tag) virtual_processor_tag <= hwdata[15:0];
            if (wr_gap) pause_gap_limit <= hwdata;
            if (wr_window) pause_window_limit <= hwdata;
            if (wr_exit) exit_control_vector <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            guest_function_controls <= `RST_DWORD;
            pointer_list_address <= `RST_DWORD;
        end else begin
            if (wr_func_lo) guest_function_controls[31:0] <= hwdata;
            if (wr_func_hi) guest_function_controls[63:32] <= hwdata;
            if (wr_list_lo) pointer_list_address[31:0] <= hwdata;
            if (wr_list_hi) pointer_list_address[63:32] <= hwdata;
        end
    end

    // A completed switch and a software write in one cycle: software wins,
    // since the monitor owns the field and may be retiring the old list
    wire sw_load = (sw_state == virt_ctl_pkg::SW_DONE) && !wr_ptr_lo && !wr_ptr_hi;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            second_level_table_pointer <= `RST_DWORD;
        end else if (sw_load) begin
            second_level_table_pointer <= fetched_pointer;
        end else begin
            if (wr_ptr_lo) second_level_table_pointer[31:0] <= hwdata;
            if (wr_ptr_hi) second_level_table_pointer[63:32] <= hwdata;
        end
    end

    // Decoded translation settings
    assign active_pointer = second_level_table_pointer;
    assign walk_mem_type = second_level_table_pointer[`MT_MSB:`MT_LSB];
    assign walk_length = {1'b0, second_level_table_pointer[`WALK_MSB:`WALK_LSB]} + 4'h1;
    assign top_level_table = {{(64 - `PHYS_WIDTH){1'b0}},
        second_level_table_pointer[`PHYS_WIDTH-1:`BASE_LSB], {`BASE_LSB{1'b0}}};
    assign active_tag = virtual_processor_tag;

    // Guest entry check, answered one cycle after the request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            entry_ok <= 1'b0;
            entry_fail <= 1'b0;
        end else begin
            entry_ok <= entry_req & entry_good;
            entry_fail <= entry_req & !entry_good;
        end
    end

    // Pause-loop timing, advanced only on timestamp ticks
    wire gap_over = gap_count > pause_gap_limit;
    wire window_over = window_count > pause_window_limit;
    wire pause_active = HAS_PAUSE_EXIT & guest_running;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_count <= `RST_WORD;
            window_count <= `RST_WORD;
            in_loop <= 1'b0;
            pause_exit <= 1'b0;
        end else begin
            pause_exit <= 1'b0;
            if (!pause_active) begin
                in_loop <= 1'b0;
                gap_count <= `RST_WORD;
                window_count <= `RST_WORD;
            end else if (pause_exec) begin
                gap_count <= `RST_WORD;
                if (!in_loop || gap_over) begin
                    in_loop <= 1'b1;
                    window_count <= `RST_WORD;
                end else if (window_over) begin
                    pause_exit <= 1'b1;
                    in_loop <= 1'b0;
                end
            end else if (timestamp_tick && in_loop) begin
                if (!(&gap_count)) gap_count <= gap_count + 32'h1;
                if (!(&window_count)) window_count <= window_count + 32'h1;
            end
        end
    end

    // Pointer switching through the in-memory list
    wire func_allowed = HAS_FUNC & guest_function_controls[`FUNC_SWITCH_BIT];
    always_comb begin
        next_sw_state = sw_state;
        unique case (sw_state)
            virt_ctl_pkg::SW_IDLE:
                if (func_req && func_allowed) next_sw_state = virt_ctl_pkg::SW_FETCH;
            virt_ctl_pkg::SW_FETCH:
                if (list_rd_valid) begin
                    next_sw_state = mem_type_ok(list_rd_data) ? virt_ctl_pkg::SW_DONE
                                                              : virt_ctl_pkg::SW_IDLE;
                end
            virt_ctl_pkg::SW_DONE: next_sw_state = virt_ctl_pkg::SW_IDLE;
            default: next_sw_state = virt_ctl_pkg::SW_IDLE;
        endcase
    end

    wire [63:0] entry_offset = {{(64 - `LIST_INDEX_WIDTH - `LIST_ENTRY_SHIFT){1'b0}},
                                func_index, {`LIST_ENTRY_SHIFT{1'b0}}};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_state <= virt_ctl_pkg::SW_IDLE;
            list_rd_req <= 1'b0;
            list_rd_addr <= `RST_DWORD;
            fetched_pointer <= `RST_DWORD;
            func_fault <= 1'b0;
        end else begin
            sw_state <= next_sw_state;
            func_fault <= 1'b0;
            if (sw_state == virt_ctl_pkg::SW_IDLE && func_req) begin
                list_rd_req <= func_allowed;
                list_rd_addr <= pointer_list_address + entry_offset;
                func_fault <= !func_allowed;
            end
            if (sw_state == virt_ctl_pkg::SW_FETCH && list_rd_valid) begin
                list_rd_req <= 1'b0;
                fetched_pointer <= list_rd_data;
                func_fault <= !mem_type_ok(list_rd_data);
            end
        end
    end

    // Exit actions; bit 9 relies on software keeping it clear on 32-bit parts
    wire host_long = exit_control_vector[`EXIT_HOST_LONG];
    wire ack_on = exit_control_vector[`EXIT_ACK_INTR] & exit_ext_intr;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exit_actions <= '0;
            exit_done <= 1'b0;
        end else begin
            exit_done <= exit_req;
            if (exit_req) begin
                exit_actions.save_debug <= exit_control_vector[`EXIT_SAVE_DEBUG];
                exit_actions.host_long <= host_long;
                exit_actions.cs_long <= host_long;
                exit_actions.efer_lme <= host_long;
                exit_actions.efer_lma <= host_long;
                exit_actions.load_perf <= exit_control_vector[`EXIT_LOAD_PERF];
                exit_actions.intr_ack <= ack_on;
                exit_actions.intr_info_valid <= ack_on;
                exit_actions.intr_vector <= ack_on ? intr_ctrl_vector : 8'h00;
                exit_actions.save_pat <= exit_control_vector[`EXIT_SAVE_PAT];
                exit_actions.load_pat <= exit_control_vector[`EXIT_LOAD_PAT];
                exit_actions.save_efer <= exit_control_vector[`EXIT_SAVE_EFER];
                exit_actions.load_efer <= exit_control_vector[`EXIT_LOAD_EFER];
                exit_actions.save_preempt <= exit_control_vector[`EXIT_SAVE_PREEMPT];
            end
        end
    end
endmodule // virt_ctl_fields

// >>> virt_ctl_fields_chk.sv
module virt_ctl_fields_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pause_exec,
    input wire logic pause_exit,
    input wire logic entry_req,
    input wire logic entry_ok,
    input wire logic entry_fail,
    input wire logic list_rd_req,
    input wire logic list_rd_valid,
    input wire logic [63:0] list_rd_addr,
    input wire logic [63:0] active_pointer,
    input wire logic [3:0] walk_length,
    input wire logic [2:0] walk_mem_type,
    input wire logic [63:0] top_level_table,
    input wire logic exit_req,
    input wire logic exit_ext_intr,
    input wire logic [7:0] intr_ctrl_vector,
    input wire logic exit_done,
    input virt_ctl_pkg::exit_actions_s exit_actions
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_mem_type;
        walk_mem_type == active_pointer[2:0];
    endproperty
    a_mem_type: assert property (p_mem_type) else $error("walk type mismatch");
    property p_walk;
        walk_length == {1'b0, active_pointer[5:3]} + 4'h1;
    endproperty
    a_walk: assert property (p_walk) else $error("walk length mismatch");
    property p_base;
        top_level_table == {28'h0, active_pointer[35:12], 12'h000};
    endproperty
    a_base: assert property (p_base) else $error("table base mismatch");
    property p_entry;
        entry_req |=> entry_ok != entry_fail;
    endproperty
    a_entry: assert property (p_entry) else $error("entry answer missing");
    property p_list_hold;
        list_rd_req && !list_rd_valid |=> list_rd_req && $stable(list_rd_addr);
    endproperty
    a_list_hold: assert property (p_list_hold) else $error("list read dropped");
    property p_list_align;
        list_rd_req |-> list_rd_addr[2:0] == 3'h0;
    endproperty
    a_list_align: assert property (p_list_align) else $error("list entry misaligned");
    property p_exit_done;
        exit_req |=> exit_done;
    endproperty
    a_exit_done: assert property (p_exit_done) else $error("exit not done");
    property p_long;
        exit_done |-> exit_actions.cs_long == exit_actions.host_long
            && exit_actions.efer_lme == exit_actions.host_long
            && exit_actions.efer_lma == exit_actions.host_long;
    endproperty
    a_long: assert property (p_long) else $error("long flags differ");
    property p_no_intr;
        exit_req && !exit_ext_intr |=> !exit_actions.intr_ack && !exit_actions.intr_info_valid;
    endproperty
    a_no_intr: assert property (p_no_intr) else $error("ack without interrupt");
    property p_vector;
        exit_done && exit_actions.intr_info_valid
            |-> exit_actions.intr_ack && exit_actions.intr_vector == $past(intr_ctrl_vector);
    endproperty
    a_vector: assert property (p_vector) else $error("vector mismatch");
    property p_pause;
        pause_exit |-> $past(pause_exec);
    endproperty
    a_pause: assert property (p_pause) else $error("exit without pause");
endmodule // virt_ctl_fields_chk

bind virt_ctl_fields virt_ctl_fields_chk u_chk (.hclk(hclk), .hresetn(hresetn),
    .pause_exec(pause_exec), .pause_exit(pause_exit), .entry_req(entry_req),
    .entry_ok(entry_ok), .entry_fail(entry_fail), .list_rd_req(list_rd_req),
    .list_rd_valid(list_rd_valid), .list_rd_addr(list_rd_addr),
    .active_pointer(active_pointer), .walk_length(walk_length),
    .walk_mem_type(walk_mem_type), .top_level_table(top_level_table),
    .exit_req(exit_req), .exit_ext_intr(exit_ext_intr),
    .intr_ctrl_vector(intr_ctrl_vector), .exit_done(exit_done), .exit_actions(exit_actions));

// >>> virt_ctl_fields_tb.sv
`include "virt_ctl_regs.svh"

module virt_ctl_fields_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, timestamp_tick, guest_running;
    logic pause_exec, pause_exit, entry_req, entry_ok, entry_fail, func_req, func_fault;
    logic list_rd_req, list_rd_valid, exit_req, exit_ext_intr, exit_done;
    logic [31:0] haddr, hwdata, hrdata, rd, v, h;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [8:0] func_index;
    logic [63:0] list_rd_addr, list_rd_data, active_pointer, top_level_table;
    logic [3:0] walk_length;
    logic [2:0] walk_mem_type;
    logic [15:0] active_tag;
    logic [7:0] intr_ctrl_vector, a;
    virt_ctl_pkg::exit_actions_s exit_actions, ex;
    int fail_count, checks_done;
    logic [7:0] eo[6] = '{`OFS_FUNC_HI, `OFS_FUNC_LO, `OFS_FUNC_LO, `OFS_PTR_LO, `OFS_PTR_LO,
        `OFS_PTR_HI};
    logic [31:0] ev[6] = '{32'h8000_0000, 32'h2, 32'h1, 32'h3, 32'h46, 32'h10};
    logic ef[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    // The single slave's ready is the bus ready
    assign hready = hreadyout;

    virt_ctl_fields dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hresp, .hrdata, .timestamp_tick, .guest_running, .pause_exec,
        .pause_exit, .entry_req, .entry_ok, .entry_fail, .func_req, .func_index, .func_fault,
        .list_rd_req, .list_rd_addr, .list_rd_valid, .list_rd_data, .active_pointer,
        .walk_length, .walk_mem_type, .top_level_table, .active_tag, .exit_req,
        .exit_ext_intr, .intr_ctrl_vector, .exit_done, .exit_actions);

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("mismatches %0d of %0d compares", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic entry(input logic fl);
        entry_req <= 1'b1;
        @(posedge hclk);
        entry_req <= 1'b0;
        #1 check({entry_ok, entry_fail}, {~fl, fl});
        @(posedge hclk);
    endtask

    function automatic virt_ctl_pkg::exit_actions_s exp_exit(input logic [31:0] c,
        input logic e, input logic [7:0] vec);
        logic k;
        k = c[15] & e;
        return '{c[2], c[9], c[9], c[9], c[9], c[12], k, k, k ? vec : 8'h00, c[18], c[19],
            c[20], c[21], c[22]};
    endfunction

    task automatic switch_ptr(input logic [8:0] idx, input logic [63:0] d, input logic fl,
        input logic [63:0] ap);
        logic f, g, s;
        f = 1'b0;
        g = 1'b0;
        func_index <= idx;
        func_req <= 1'b1;
        repeat (8) begin
            @(posedge hclk);
            func_req <= 1'b0;
            f = f | (func_fault === 1'b1);
            s = list_rd_req === 1'b1 && !g;
            list_rd_valid <= s;
            list_rd_data <= s ? d : ~d;
            if (s) check(list_rd_addr, 64'h1_abcd_e000 + {idx, 3'b000});
            g = g | s;
        end
        #1 check(f, fl);
        check(active_pointer, ap);
        @(posedge hclk);
    endtask

    initial begin
        #800000;
        fail_count++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h77de));
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, timestamp_tick, guest_running} = '0;
        {pause_exec, entry_req, func_req, func_index, list_rd_valid, list_rd_data} = '0;
        {exit_req, exit_ext_intr, intr_ctrl_vector} = '0;
        hsize = 3'h2;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 12; i++) begin
            a = (i < 10) ? 8'(i * 4) : (i == 10) ? `OFS_STATUS : 8'h80;
            bus(1'b0, a, 32'h0);
            check(rd, (a == `OFS_STATUS) ? 32'hf : 32'h0);
            check({hreadyout, hresp}, 2'b10);
        end
        bus(1'b1, 8'h80, $urandom);
        bus(1'b0, 8'h80, 32'h0);
        check(rd, 0);
        for (int i = 0; i < 30; i++) begin
            a = 8'(($urandom % 10) * 4);
            v = $urandom;
            bus(1'b1, a, v);
            bus(1'b0, a, 32'h0);
            check(rd, (a == `OFS_TAG) ? (v & 32'hffff) : v);
            if (a == `OFS_TAG) check(active_tag, v[15:0]);
        end
        for (int i = 0; i < 12; i++) begin
            v = {$urandom} & 32'hffff_f038 | ((i % 2) ? 32'h6 : 32'h0);
            h = $urandom & 32'hf;
            bus(1'b1, `OFS_PTR_LO, v);
            bus(1'b1, `OFS_PTR_HI, h);
            @(posedge hclk);
            #1 check(active_pointer, {h, v});
            check(walk_length, v[5:3] + 4'h1);
            check(walk_mem_type, v[2:0]);
            check(top_level_table, {28'h0, h[3:0], v[31:12], 12'h0});
            @(posedge hclk);
        end
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, `OFS_PTR_LO, 32'h1006);
            bus(1'b1, `OFS_PTR_HI, 32'h0);
            bus(1'b1, `OFS_FUNC_LO, 32'h0);
            bus(1'b1, `OFS_FUNC_HI, 32'h0);
            bus(1'b1, eo[i], ev[i]);
            entry(ef[i]);
        end
        for (int i = 0; i < 16; i++) begin
            v = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom;
            bus(1'b1, `OFS_EXIT, v);
            exit_req <= 1'b1;
            exit_ext_intr <= (i == 0) | 1'($urandom);
            intr_ctrl_vector <= 8'($urandom);
            @(posedge hclk);
            exit_req <= 1'b0;
            #1 check(exit_done, 1'b1);
            ex = exp_exit(v, exit_ext_intr, intr_ctrl_vector);
            check(exit_actions, ex);
            @(posedge hclk);
        end
        bus(1'b1, `OFS_PTR_HI, 32'h0);
        bus(1'b1, `OFS_LIST_LO, 32'habcd_e000);
        bus(1'b1, `OFS_LIST_HI, 32'h1);
        bus(1'b1, `OFS_FUNC_LO, 32'h0);
        switch_ptr(9'd3, 64'h0, 1'b1, 64'h1006);
        bus(1'b1, `OFS_FUNC_LO, 32'h1);
        switch_ptr(9'd511, 64'h5_0000_201e, 1'b0, 64'h5_0000_201e);
        switch_ptr(9'd0, 64'h7000_3005, 1'b1, 64'h5_0000_201e);
        bus(1'b1, `OFS_GAP, 32'h2);
        bus(1'b1, `OFS_WINDOW, 32'h3);
        guest_running <= 1'b1;
        // Each tick adds one to the window; the fifth pause sees 4 > 3
        for (int i = 0; i < 6; i++) begin
            pause_exec <= 1'b1;
            @(posedge hclk);
            pause_exec <= 1'b0;
            timestamp_tick <= 1'b1;
            #1 check(pause_exit, i == 4);
            @(posedge hclk);
            timestamp_tick <= 1'b0;
        end
        // A long gap starts a fresh loop, so the over-full window must not exit
        timestamp_tick <= 1'b1;
        repeat (4) @(posedge hclk);
        timestamp_tick <= 1'b0;
        pause_exec <= 1'b1;
        @(posedge hclk);
        pause_exec <= 1'b0;
        #1 check(pause_exit, 1'b0);
        complete_run();
    end
endmodule // virt_ctl_fields_tb

// >>> virt_ctl_pkg.sv
package virt_ctl_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } bus_phase_s;

    typedef struct packed {
        logic save_debug;
        logic host_long;
        logic cs_long;
        logic efer_lme;
        logic efer_lma;
        logic load_perf;
        logic intr_ack;
        logic intr_info_valid;
        logic [7:0] intr_vector;
        logic save_pat;
        logic load_pat;
        logic save_efer;
        logic load_efer;
        logic save_preempt;
    } exit_actions_s;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_FETCH = 2'b01,
        SW_DONE = 2'b11
    } switch_state_e;
endpackage

// >>> virt_ctl_regs.svh
`ifndef VIRT_CTL_REGS_SVH
`define VIRT_CTL_REGS_SVH
// Contract
// - Pointer bits 2:0 memory type; 0 uncacheable, 6 write-back
// - Pointer bits 5:3 hold walk length minus one
// - Pointer bits N-1:12 table base; rest reserved
// - Pointer field exists only with translation support; a completed list switch still loads it when translation is absent
// - 16-bit processor tag exists only with tag support
// - Two 32-bit pause limits when pause exiting supported
// - Gap limit bounds time between loop pauses
// - Window limit bounds total time in loop
// - Pause limits count at timestamp counter rate
// - 64-bit guest-function vector needs both enable settings
// - Function bit 0 switches pointer from list
// - Reserved function bits set fail later entries
// - List address: 512 eight-byte pointer entries
// - 32-bit exit control vector steers exit operations
// - Exit bit 2 saves debug registers
// - Exit bit 9 copied to long-mode flags
// - Exit bit 12 loads performance global control
// - Exit bit 15 acknowledges interrupt, marks info valid
// - Exit bits 18/19 save/load page attributes
// - Exit bits 20/21 save/load extended features
// - Exit bit 22 saves preemption timer

`define OFS_PTR_LO 8'h00
`define OFS_PTR_HI 8'h04
`define OFS_TAG 8'h08
`define OFS_GAP 8'h0c
`define OFS_WINDOW 8'h10
`define OFS_FUNC_LO 8'h14
`define OFS_FUNC_HI 8'h18
`define OFS_LIST_LO 8'h1c
`define OFS_LIST_HI 8'h20
`define OFS_EXIT 8'h24
`define OFS_STATUS 8'h28

`define MT_LSB 0
`define MT_MSB 2
`define WALK_LSB 3
`define WALK_MSB 5
`define BASE_LSB 12
`define PHYS_WIDTH 36
`define MT_UNCACHEABLE 3'h0
`define MT_WRITE_BACK 3'h6
`define FUNC_DEFINED_MASK 64'h0000_0000_0000_0001
`define FUNC_SWITCH_BIT 0
`define LIST_INDEX_WIDTH 9
`define LIST_ENTRY_SHIFT 3

`define EXIT_SAVE_DEBUG 2
`define EXIT_HOST_LONG 9
`define EXIT_LOAD_PERF 12
`define EXIT_ACK_INTR 15
`define EXIT_SAVE_PAT 18
`define EXIT_LOAD_PAT 19
`define EXIT_SAVE_EFER 20
`define EXIT_LOAD_EFER 21
`define EXIT_SAVE_PREEMPT 22

`define RST_WORD 32'h0000_0000
`define RST_DWORD 64'h0000_0000_0000_0000
`define RST_TAG 16'h0000
`endif
